/* File: fill_cpu_model.sv */
// processor model driving the register and memory port
`timescale 1ns/1ns
module fill_cpu_model
(
    // clock
    input  wire logic        clk,
    // processor port
    output      logic        cpu_wr,
    output      logic        cpu_rd,
    output      logic [15:0] cpu_addr,
    output      logic [15:0] cpu_wdata,
    input  wire logic [15:0] cpu_rdata_q,
    input  wire logic        cpu_rvalid_q
);
    initial
    begin
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 16'h0000;
    end
    // one write, held through its taking edge; data then shows no stale value
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
        cpu_wdata = ~d;
    endtask
    // one read; answer awaited for at most two cycles
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        d = 16'hxxxx;
        if (cpu_rvalid_q !== 1'b1)
            @(negedge clk);
        if (cpu_rvalid_q === 1'b1)
            d = cpu_rdata_q;
    endtask
endmodule

/* File: fill_engine.sv */
// connection-memory block fill engine with its registers and memories
`timescale 1ns/1ns
//
// Behaviour
// - full fill writes pattern everywhere, each location once
// - fill starts when go bit set
// - full fill ignores group data rate; block fill wraps channel at the group rate's last channel
// - clear-low bit zeroes low word, else kept
// - go and pattern bits clear on completion
// - one high location written per cycle
// - stream inner loop, channel outer loop
// - run start to end, never reject
// - start beyond end wraps per dimension
// - start bits 14-12 pick group, bit15 zero
// - start stream 11-9, start channel 8-0
// - end stream 11-9, end channel 8-0
// - group taken from start address register
// - full select ignores address registers
// - writing go low aborts fill
// - control bit positions 8,7-5,4,3
module fill_engine
(
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // microprocessor port, synchronous to clk
    input  wire logic                         cpu_wr,
    input  wire logic                         cpu_rd,
    input  wire logic [fill_pkg::ADDR_W-1:0]  cpu_addr,
    input  wire logic [fill_pkg::DATA_W-1:0]  cpu_wdata,
    output      logic [fill_pkg::DATA_W-1:0]  cpu_rdata_q,
    output      logic                         cpu_rvalid_q,
    // group data rate per group, eight groups
    input  wire logic [8*fill_pkg::RATE_W-1:0] group_rate,
    // fill status
    output      logic                         fill_busy_q
);
    import fill_pkg::*;

    // =========================================================
    // registers
    logic [15:0] ctrl_q;
    logic [15:0] start_q;
    logic [15:0] end_q;
    logic        done;
    logic        full_q;
    logic [2:0]  grp_q;
    logic [2:0]  st_q;
    logic [8:0]  ch_q;
    logic [2:0]  st_lo_q;
    logic [2:0]  st_hi_q;
    logic [8:0]  ch_hi_q;
    logic [8:0]  max_ch_q;
    logic [2:0]  pat_q;
    logic        clr_q;

    logic        reg_sel;
    logic [6:0]  reg_idx;
    logic        mem_sel;
    logic        cpu_mem_wr;
    assign mem_sel = cpu_addr[15];
    assign reg_sel = ~cpu_addr[15];
    assign reg_idx = cpu_addr[15:9];
    assign cpu_mem_wr = cpu_wr && mem_sel;

    wire go_write = cpu_wr && reg_sel && reg_idx == REG_CTRL;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else if (go_write)
        begin
            ctrl_q <= cpu_wdata;
        end
        else if (done)
        begin
            ctrl_q[CTRL_GO] <= 1'b0;
            ctrl_q[CTRL_PAT_HI:CTRL_PAT_LO] <= 3'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            start_q <= START_RESET;
            end_q   <= END_RESET;
        end
        else if (cpu_wr && reg_sel)
        begin
            if (reg_idx == REG_START)
            begin
                start_q <= {1'b0, cpu_wdata[14:0]};
            end
            if (reg_idx == REG_END)
            begin
                end_q <= cpu_wdata;
            end
        end
    end

    // =========================================================
    // rate-dependent last channel of the selected group
    function automatic logic [8:0] last_chan(input logic [2:0] r);
        case (r)
            RATE_2M:  last_chan = 9'h01f;
            RATE_4M:  last_chan = 9'h03f;
            RATE_8M:  last_chan = 9'h07f;
            RATE_16M: last_chan = 9'h0ff;
            default:  last_chan = LAST_CHAN_32M;
        endcase
    endfunction

    // =========================================================
    // fill sequencer
    typedef enum {S_IDLE, S_RUN} fill_state_t;
    fill_state_t state_q;

    logic       go_rise;
    logic       go_prev_q;
    logic       last_st;
    logic       last_ch;
    logic [2:0] st_next;
    logic [8:0] ch_next;
    logic [2:0] sel_grp;
    logic [2:0] sel_rate;

    assign go_rise  = ctrl_q[CTRL_GO] && !go_prev_q;
    assign sel_grp  = start_q[GRP_HI:GRP_LO];
    assign sel_rate = group_rate[sel_grp*RATE_W +: RATE_W];

    // stream and channel wrap on their own, so start beyond end covers the rest
    assign last_st  = st_q == st_hi_q;
    assign last_ch  = ch_q == ch_hi_q;
    assign st_next  = (st_q == LAST_STREAM) ? 3'h0 : st_q + 3'h1;
    assign ch_next  = (ch_q == max_ch_q) ? 9'h000 : ch_q + 9'h001;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            go_prev_q <= 1'b0;
        end
        else
        begin
            go_prev_q <= ctrl_q[CTRL_GO];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q  <= S_IDLE;
            full_q   <= 1'b0;
            grp_q    <= 3'h0;
            st_q     <= 3'h0;
            ch_q     <= 9'h000;
            st_lo_q  <= 3'h0;
            st_hi_q  <= 3'h0;
            ch_hi_q  <= 9'h000;
            max_ch_q <= 9'h000;
            pat_q    <= 3'h0;
            clr_q    <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (go_rise)
                    begin
                        state_q <= S_RUN;
                        pat_q   <= ctrl_q[CTRL_PAT_HI:CTRL_PAT_LO];
                        clr_q   <= ctrl_q[CTRL_CLR_LOW];
                        full_q  <= ctrl_q[CTRL_FULL];
                        if (ctrl_q[CTRL_FULL])
                        begin
                            // whole memory, group by group, no wrap
                            grp_q    <= 3'h0;
                            st_q     <= 3'h0;
                            ch_q     <= 9'h000;
                            st_lo_q  <= 3'h0;
                            st_hi_q  <= LAST_STREAM;
                            ch_hi_q  <= LAST_CHAN_32M;
                            max_ch_q <= LAST_CHAN_32M;
                        end
                        else
                        begin
                            grp_q    <= sel_grp;
                            st_q     <= start_q[STR_HI:STR_LO];
                            ch_q     <= start_q[CH_HI:CH_LO];
                            st_lo_q  <= start_q[STR_HI:STR_LO];
                            st_hi_q  <= end_q[STR_HI:STR_LO];
                            ch_hi_q  <= end_q[CH_HI:CH_LO];
                            max_ch_q <= last_chan(sel_rate);
                        end
                    end
                end
                S_RUN:
                begin
                    if (!ctrl_q[CTRL_GO] || done)
                    begin
                        state_q <= S_IDLE;
                    end
                    else if (!cpu_mem_wr)
                    begin
                        // stream is the inner loop
                        if (last_st)
                        begin
                            st_q <= st_lo_q;
                            ch_q <= ch_next;
                            if (last_ch && full_q)
                            begin
                                grp_q <= grp_q + 3'h1;
                            end
                        end
                        else
                        begin
                            st_q <= st_next;
                        end
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // last write of the walk; full fill ends after group 7
    assign done = (state_q == S_RUN) && ctrl_q[CTRL_GO] && !cpu_mem_wr
                  && last_st && last_ch && (!full_q || grp_q == 3'h7);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fill_busy_q <= 1'b0;
        end
        else
        begin
            // high from the go edge until the last write or an abort
            fill_busy_q <= ((state_q == S_IDLE) && go_rise)
                           || ((state_q == S_RUN) && ctrl_q[CTRL_GO] && !done);
        end
    end

    // =========================================================
    // connection memory write arbitration
    logic                fill_we;
    logic [MEM_AW-1:0]   fill_addr;
    logic [MEM_AW-1:0]   waddr;
    logic [14:0]         hi_wdata;
    logic [14:0]         lo_wdata;
    logic                hi_we;
    logic                lo_we;
    logic [14:0]         hi_rdata;
    logic [14:0]         lo_rdata;

    assign fill_we   = (state_q == S_RUN) && ctrl_q[CTRL_GO] && !cpu_mem_wr;
    assign fill_addr = {grp_q, st_q, ch_q};
    // processor memory write takes the port; the fill stalls that cycle
    assign waddr     = cpu_mem_wr ? cpu_addr[14:0] : fill_addr;
    assign hi_we     = cpu_mem_wr ? (ctrl_q[1:0] == 2'b01) : fill_we;
    assign lo_we     = cpu_mem_wr ? (ctrl_q[1:0] == 2'b00) : (fill_we && clr_q);
    assign hi_wdata  = cpu_mem_wr ? cpu_wdata[14:0] : {12'h000, pat_q};
    assign lo_wdata  = cpu_mem_wr ? cpu_wdata[14:0] : 15'h0000;

    fill_mem u_high
    (
        .clk     (clk),
        .we      (hi_we),
        .waddr   (waddr),
        .wdata   (hi_wdata),
        .raddr   (cpu_addr[14:0]),
        .rdata_q (hi_rdata)
    );

    fill_mem u_low
    (
        .clk     (clk),
        .we      (lo_we),
        .waddr   (waddr),
        .wdata   (lo_wdata),
        .raddr   (cpu_addr[14:0]),
        .rdata_q (lo_rdata)
    );

    // =========================================================
    // read path, answer two cycles after the request
    logic        rd_pend_q;
    logic        rd_mem_q;
    logic        rd_lo_q;
    logic [15:0] rd_reg_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_mem_q     <= 1'b0;
            rd_lo_q      <= 1'b0;
            rd_reg_q     <= 16'h0000;
            rd_pend_q    <= 1'b0;
            cpu_rvalid_q <= 1'b0;
            cpu_rdata_q  <= 16'h0000;
        end
        else
        begin
            rd_mem_q     <= cpu_rd && mem_sel;
            rd_lo_q      <= ctrl_q[1:0] == 2'b00;
            rd_pend_q    <= cpu_rd;
            cpu_rvalid_q <= rd_pend_q;
            cpu_rdata_q  <= rd_mem_q ? {1'b0, rd_lo_q ? lo_rdata : hi_rdata} : rd_reg_q;
            case (reg_idx)
                REG_CTRL:  rd_reg_q <= ctrl_q;
                REG_START: rd_reg_q <= start_q;
                REG_END:   rd_reg_q <= end_q;
                default:   rd_reg_q <= 16'h0000;
            endcase
        end
    end
endmodule

/* File: fill_mem.sv */
// one word-wide connection memory array with registered read data
`timescale 1ns/1ns
module fill_mem
(
    // clock
    input  wire logic                        clk,
    // write port
    input  wire logic                        we,
    input  wire logic [fill_pkg::MEM_AW-1:0] waddr,
    input  wire logic [14:0]                 wdata,
    // read port
    input  wire logic [fill_pkg::MEM_AW-1:0] raddr,
    output      logic [14:0]                 rdata_q
);
    import fill_pkg::*;

    logic [14:0] mem [0:(1<<MEM_AW)-1];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule

/* File: fill_pkg.sv */
// constants for the connection-memory block fill engine
package fill_pkg;
    localparam int ADDR_W        = 16;
    localparam int DATA_W        = 16;
    // register addresses (upper address bits select the register)
    localparam logic [6:0] REG_CTRL  = 7'h00;
    localparam logic [6:0] REG_START = 7'h05;
    localparam logic [6:0] REG_END   = 7'h06;
    // control register fields
    localparam int CTRL_FULL     = 8;
    localparam int CTRL_PAT_HI   = 7;
    localparam int CTRL_PAT_LO   = 5;
    localparam int CTRL_GO       = 4;
    localparam int CTRL_CLR_LOW  = 3;
    // address register fields
    localparam int GRP_HI        = 14;
    localparam int GRP_LO        = 12;
    localparam int STR_HI        = 11;
    localparam int STR_LO        = 9;
    localparam int CH_HI         = 8;
    localparam int CH_LO         = 0;
    // reset values
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    localparam logic [15:0] START_RESET = 16'h0000;
    localparam logic [15:0] END_RESET   = 16'hf000;
    // memory geometry: 64 streams x 512 channels
    localparam int MEM_AW        = 15;
    localparam logic [2:0] LAST_STREAM = 3'h7;
    localparam logic [8:0] LAST_CHAN_32M = 9'h1ff;
    localparam int RATE_W        = 3;
    typedef enum logic [2:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M, RATE_32M} rate_t;
endpackage

/* File: fill_props.sv */
// assertion checker for the block fill engine
`timescale 1ns/1ns
module fill_props
import fill_pkg::*;
(
    // clock and reset
    input wire logic                          clk,
    input wire logic                          rst_b,
    // processor port
    input wire logic                          cpu_wr,
    input wire logic                          cpu_rd,
    input wire logic [fill_pkg::ADDR_W-1:0]   cpu_addr,
    input wire logic [fill_pkg::DATA_W-1:0]   cpu_wdata,
    input wire logic [fill_pkg::DATA_W-1:0]   cpu_rdata_q,
    input wire logic                          cpu_rvalid_q,
    // group rates and status
    input wire logic [8*fill_pkg::RATE_W-1:0] group_rate,
    input wire logic                          fill_busy_q
);
    // =====
    // helpers
    logic        ctl_wr;
    logic        go_wr;
    logic [15:0] busy_cnt_q;
    assign ctl_wr = cpu_wr && cpu_addr[15:9] == REG_CTRL;
    assign go_wr = ctl_wr && cpu_wdata[CTRL_GO];
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            busy_cnt_q <= 16'h0000;
        else if (fill_busy_q)
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        else
            busy_cnt_q <= 16'h0000;
    end
    // =====
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RD_ANSWER: assert property (cpu_rd |-> ##2 cpu_rvalid_q)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (cpu_rvalid_q |-> $past(cpu_rd, 2))
        else $error("read valid without read");
    AST_GO_START: assert property (go_wr && !fill_busy_q |-> ##[1:2] fill_busy_q)
        else $error("fill did not start");
    AST_START_CAUSE: assert property ($rose(fill_busy_q) |-> $past(go_wr) || $past(go_wr, 2))
        else $error("fill started without go");
    AST_ABORT: assert property (ctl_wr && !cpu_wdata[CTRL_GO] && fill_busy_q |-> ##[1:3] !fill_busy_q)
        else $error("abort ignored");
    AST_BUSY_LIMIT: assert property (busy_cnt_q <= 16'h8003)
        else $error("fill runs too long");
    AST_GO_CLEARED: assert property (cpu_rd && cpu_addr[15:9] == REG_CTRL && !cpu_wr
        && !fill_busy_q && !$past(fill_busy_q) && !$past(cpu_wr) |-> ##2 !cpu_rdata_q[CTRL_GO])
        else $error("go bit left set");
    AST_START_READBACK: assert property (cpu_wr && cpu_addr[15:9] == REG_START ##2 cpu_rd
        && cpu_addr[15:9] == REG_START |-> ##2
        (cpu_rdata_q & 16'h7fff) == ($past(cpu_wdata, 4) & 16'h7fff))
        else $error("start register readback");
    AST_END_READBACK: assert property (cpu_wr && cpu_addr[15:9] == REG_END ##2 cpu_rd
        && cpu_addr[15:9] == REG_END |-> ##2
        (cpu_rdata_q & 16'h0fff) == ($past(cpu_wdata, 4) & 16'h0fff))
        else $error("end register readback");
    AST_RESET_QUIET: assert property (!$past(rst_b) |-> !fill_busy_q && !cpu_rvalid_q)
        else $error("outputs active after reset");
endmodule
bind fill_engine fill_props u_props
(
    .clk(clk),
    .rst_b(rst_b),
    .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata),
    .cpu_rdata_q(cpu_rdata_q),
    .cpu_rvalid_q(cpu_rvalid_q),
    .group_rate(group_rate),
    .fill_busy_q(fill_busy_q)
);

/* File: tb.sv */
// testbench for the block fill engine
`timescale 1ns/1ns
module tb;
    import fill_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [15:0] cpu_addr;
    logic [15:0] cpu_wdata;
    logic [15:0] cpu_rdata_q;
    logic        cpu_rvalid_q;
    logic [23:0] group_rate;
    logic        fill_busy_q;
    logic [15:0] v;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;
    int          busy_cyc = 0;
    int          in_s[5] = '{14, 15, 8, 9, 14};
    int          in_c[5] = '{30, 31, 0, 2, 1};
    int          out_s[5] = '{10, 14, 13, 14, 14};
    int          out_c[5] = '{0, 3, 31, 29, 100};
    fill_cpu_model u_cpu (.clk(clk), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .cpu_rvalid_q(cpu_rvalid_q));
    fill_engine u_dut (.clk(clk), .rst_b(rst_b), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
        .cpu_rvalid_q(cpu_rvalid_q), .group_rate(group_rate), .fill_busy_q(fill_busy_q));
    // =====
    // clock, hang limit and busy length
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (fill_busy_q === 1'b1)
            busy_cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            summarize();
        end
    end
    // =====
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [15:0] ctl(input int full, pat, go, clr, ms);
        return 16'((full << CTRL_FULL) | (pat << CTRL_PAT_LO) | (go << CTRL_GO)
            | (clr << CTRL_CLR_LOW) | ms);
    endfunction
    task automatic chk(input int s, input int c, input logic [15:0] m, input logic [15:0] e);
        u_cpu.rd({1'b1, 6'(s), 9'(c)}, v);
        check(v & m, e);
    endtask
    task automatic fill(input logic [15:0] c, input int lo);
        int k;
        busy_cyc = 0;
        u_cpu.wr(16'h0000, c);
        repeat (3) @(negedge clk);
        for (k = 0; k < 40000 && fill_busy_q !== 1'b0; k++)
            @(negedge clk);
        check(16'(busy_cyc >= lo && busy_cyc <= lo + 3), 16'h0001);
    endtask
    // =====
    // scenarios
    initial
    begin
        rst_b = 1'b0;
        group_rate = {8{3'h4}};
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        u_cpu.rd({REG_CTRL, 9'h000}, v);
        check(v, CTRL_RESET);
        u_cpu.rd({REG_START, 9'h000}, v);
        check(v, START_RESET);
        u_cpu.rd({REG_END, 9'h000}, v);
        check(v, END_RESET);
        u_cpu.rd(16'h2000, v);
        group_rate[5:3] = 3'h0;
        u_cpu.wr({REG_START, 9'h000}, 16'h1c1e);
        u_cpu.rd({REG_START, 9'h000}, v);
        check(v, 16'h1c1e);
        u_cpu.wr({REG_END, 9'h000}, 16'hf202);
        u_cpu.rd({REG_END, 9'h000}, v);
        check(v, 16'hf202);
        fill(ctl(1, 5, 1, 0, 1), 32768);
        u_cpu.rd(16'h0000, v);
        check(v, ctl(1, 0, 0, 0, 1));
        chk(63, 511, 16'h0007, 16'h0005);
        chk(0, 0, 16'h0007, 16'h0005);
        u_cpu.wr(16'h0000, ctl(0, 0, 0, 0, 0));
        u_cpu.wr({1'b1, 6'd14, 9'd30}, 16'h1234);
        u_cpu.wr({1'b1, 6'd10, 9'd0}, 16'h1234);
        fill(ctl(0, 2, 1, 1, 1), 20);
        foreach (in_s[i])
        begin
            chk(in_s[i], in_c[i], 16'h0007, 16'h0002);
            chk(out_s[i], out_c[i], 16'h0007, 16'h0005);
        end
        u_cpu.wr(16'h0000, ctl(0, 0, 0, 0, 0));
        chk(14, 30, 16'h7fff, 16'h0000);
        chk(10, 0, 16'h7fff, 16'h1234);
        u_cpu.wr({1'b1, 6'd9, 9'd2}, 16'h0abc);
        u_cpu.wr({REG_START, 9'h000}, 16'h1202);
        fill(ctl(0, 7, 1, 0, 1), 1);
        chk(9, 2, 16'h0007, 16'h0007);
        chk(9, 1, 16'h0007, 16'h0002);
        u_cpu.wr(16'h0000, ctl(0, 0, 0, 0, 0));
        chk(9, 2, 16'h7fff, 16'h0abc);
        group_rate[8:6] = 3'h3;
        u_cpu.wr({REG_START, 9'h000}, 16'h2eff);
        u_cpu.wr({REG_END, 9'h000}, 16'hf000);
        fill(ctl(0, 6, 1, 0, 1), 4);
        chk(23, 255, 16'h0007, 16'h0006);
        chk(16, 0, 16'h0007, 16'h0006);
        chk(16, 256, 16'h0007, 16'h0005);
        chk(17, 0, 16'h0007, 16'h0005);
        u_cpu.wr(16'h0000, ctl(1, 2, 1, 0, 1));
        repeat (100) @(negedge clk);
        u_cpu.wr(16'h0000, ctl(1, 2, 0, 0, 1));
        repeat (4) @(negedge clk);
        check(16'(fill_busy_q), 16'h0000);
        chk(7, 0, 16'h0007, 16'h0002);
        chk(63, 0, 16'h0007, 16'h0005);
        chk(0, 511, 16'h0007, 16'h0005);
        summarize();
    end
endmodule
